/* File: hdl/tbts_pkg.sv */
// package: constants for the 10 Mb/s transmit supervision block
package tbts_pkg;
  // clock and bit time
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned BIT_TIME_NS     = 100;
  // jabber limits in bit times (allowed: 20 ms..150 ms active, 250..750 ms off)
  localparam int unsigned JAB_LIMIT_BITS  = 300000;
  localparam int unsigned JAB_UNJAB_BITS  = 5000000;
  // heartbeat length in bit times
  localparam int unsigned SQE_LEN_BITS    = 10;
  // link pulse period
  localparam int unsigned NLP_PERIOD_MS   = 16;
  localparam int unsigned NLP_PERIOD_NS   = NLP_PERIOD_MS * 1000000;
  localparam int unsigned NLP_WIDTH_NS    = 100;
  // polarity: number of inverted pulses in a row before correction
  localparam int unsigned POL_VOTE        = 2;
  // bit-time divider, rounded down, at least one cycle
  localparam int unsigned CLK_PER_BIT     = (BIT_TIME_NS / CLK_PERIOD_NS) > 0 ?
                                            (BIT_TIME_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned NLP_PERIOD_CLK  = NLP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned NLP_WIDTH_CLK   = (NLP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {TBTS_IDLE, TBTS_RUN, TBTS_CUT} tbts_jab_type;
endpackage : tbts_pkg

/* File: hdl/tbts_lh_flag.sv */
// module: latching-high status flag cleared by a management read
`timescale 1ns/1ns
module tbts_lh_flag
  import tbts_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic event_i,
  input  wire logic read_i,
  output logic      flag_o
);
  // read clears flag
  // set wins over clear so an event during the read is not lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (event_i) begin
      flag_o <= 1'b1;
    end else if (read_i) begin
      flag_o <= 1'b0;
    end
  end

  a_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_o && !read_i |=> flag_o) else $error("flag dropped without read");
endmodule : tbts_lh_flag

/* File: hdl/tbts_top.sv */
// module: jabber, heartbeat, link pulse and polarity supervision
// How it works
// - when jabber enabled, time transmission; assert collision past activation limit
// - during jabber off period, block transmit data from line driver
// - keep sending link pulses while jabber blocks data
// - jabber event sets latching-high jabber flag
// - jabber inhibit input one disables detection, zero enables
// - heartbeat pulses collision fixed length at end of each packet not cut by jabber
// - heartbeat only in node mode, half duplex, link up, not inhibited
// - one bit time is 100 ns for all bit-based intervals
// - detect reversed receive polarity from incoming link pulse polarity
// - polarity inhibit input one disables sensing and correction
// - reversed polarity inverts receive data and sets latching flag
// - polarity check also runs during 100 Mb/s auto-negotiation
// - send and accept link pulses whenever 10 Mb/s link idle
// - emit one link pulse every 16 ms while idle
`timescale 1ns/1ns
module tbts_top
  import tbts_pkg::*;
#(
  parameter int unsigned JAB_LIMIT  = JAB_LIMIT_BITS,
  parameter int unsigned JAB_UNJAB  = JAB_UNJAB_BITS,
  parameter int unsigned SQE_LEN    = SQE_LEN_BITS,
  parameter int unsigned NLP_PERIOD = NLP_PERIOD_CLK
)(
  input  wire logic REF_CLK_I,
  input  wire logic RST_N_I,
  input  wire logic TX_EN_I,
  input  wire logic TXD_I,
  input  wire logic RX_PAIR_POSITIVE_I,
  input  wire logic RX_PAIR_NEGATIVE_I,
  input  wire logic RX_DATA_I,
  input  wire logic RX_ACTIVE_I,
  input  wire logic MODE_10M_I,
  input  wire logic AUTONEG_BUSY_I,
  input  wire logic REPEATER_MODE_I,
  input  wire logic FULL_DUPLEX_I,
  input  wire logic LINK_VALID_I,
  input  wire logic JABBER_INHIBIT_I,
  input  wire logic SQE_INHIBIT_I,
  input  wire logic POL_INHIBIT_I,
  input  wire logic STATUS17_READ_I,
  input  wire logic STATUS18_READ_I,
  output logic      COL_O,
  output logic      LINE_DATA_O,
  output logic      LINE_EN_O,
  output logic      LINK_PULSE_O,
  output logic      RX_DATA_O,
  output logic      JABBER_FLAG_O,
  output logic      POL_REV_FLAG_O
);
  // ****************************************
  // input synchronisers
  // ****************************************
  // all inputs arrive from outside this clock, two flops each
  localparam int unsigned NIN = 14;
  logic [NIN-1:0] raw, s1, s2;
  assign raw = {TX_EN_I, TXD_I, RX_PAIR_POSITIVE_I, RX_PAIR_NEGATIVE_I, RX_DATA_I,
                RX_ACTIVE_I, MODE_10M_I, AUTONEG_BUSY_I, REPEATER_MODE_I, FULL_DUPLEX_I,
                LINK_VALID_I, JABBER_INHIBIT_I, SQE_INHIBIT_I, POL_INHIBIT_I};
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic tx_en, txd, rxp, rxn, rxd, rx_act, m10, an_busy, rep, fdx, link, jab_inh;
  logic sqe_inh, pol_inh;
  assign {tx_en, txd, rxp, rxn, rxd, rx_act, m10, an_busy, rep, fdx, link, jab_inh,
          sqe_inh, pol_inh} = s2;
  // read strobes kept apart so each flag clears on its own register read
  logic rd17_s1, rd17, rd18_s1, rd18, rd17_d, rd18_d;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd17_s1 <= 1'b0;
      rd17    <= 1'b0;
      rd18_s1 <= 1'b0;
      rd18    <= 1'b0;
      rd17_d  <= 1'b0;
      rd18_d  <= 1'b0;
    end else begin
      rd17_s1 <= STATUS17_READ_I;
      rd17    <= rd17_s1;
      rd18_s1 <= STATUS18_READ_I;
      rd18    <= rd18_s1;
      rd17_d  <= rd17;
      rd18_d  <= rd18;
    end
  end
  wire rd17_p = rd17 & ~rd17_d;
  wire rd18_p = rd18 & ~rd18_d;

  // ****************************************
  // bit-time tick
  // ****************************************
  // 100 ns bit tick
  // phase kept in ns: 2.5 clocks per bit, ticks alternate 3 and 2 clocks apart
  logic [7:0] bph;
  wire        bit_tick = (32'(bph) + CLK_PERIOD_NS >= BIT_TIME_NS);
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) bph <= '0;
    else if (bit_tick) bph <= 8'(32'(bph) + CLK_PERIOD_NS - BIT_TIME_NS);
    else bph <= 8'(32'(bph) + CLK_PERIOD_NS);
  end

  // ****************************************
  // jabber
  // ****************************************
  tbts_jab_type jst;
  logic [22:0]  jcnt;
  logic         jab_event;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      jst  <= TBTS_IDLE;
      jcnt <= '0;
    end else begin
      case (jst)
        TBTS_IDLE: begin
          jcnt <= '0;
          if (tx_en && !jab_inh) jst <= TBTS_RUN;
        end
        TBTS_RUN: begin
          if (!tx_en || jab_inh) begin
            jst <= TBTS_IDLE;
          end else if (jcnt >= 23'(JAB_LIMIT)) begin
            jst  <= TBTS_CUT;
            jcnt <= '0;
          end else if (bit_tick) begin
            jcnt <= jcnt + 23'h1;
          end
        end
        TBTS_CUT: begin
          // off period, then wait for transmit enable to drop
          if (jcnt >= 23'(JAB_UNJAB) && !tx_en) jst <= TBTS_IDLE;
          else if (bit_tick && jcnt < 23'(JAB_UNJAB)) jcnt <= jcnt + 23'h1;
        end
        default: jst <= TBTS_IDLE;
      endcase
    end
  end
  assign jab_event = (jst == TBTS_CUT);

  // ****************************************
  // heartbeat
  // ****************************************
  // counted in clocks so the pulse length does not depend on the tick phase
  localparam int unsigned SQE_CYC = (SQE_LEN * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  logic       tx_en_d;
  logic [4:0] sqe_cnt;
  wire sqe_ok = !rep && !fdx && link && !sqe_inh;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_en_d <= 1'b0;
      sqe_cnt <= '0;
    end else begin
      tx_en_d <= tx_en;
      if (tx_en_d && !tx_en && sqe_ok && jst != TBTS_CUT) sqe_cnt <= 5'(SQE_CYC);
      else if (sqe_cnt != '0) sqe_cnt <= sqe_cnt - 5'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) COL_O <= 1'b0;
    else COL_O <= jab_event || (sqe_cnt != '0);
  end

  // ****************************************
  // link pulses and line driver
  // ****************************************
  logic [24:0] nlp_cnt;
  logic [1:0]  nlp_w;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nlp_cnt <= '0;
      nlp_w   <= '0;
    end else if (nlp_cnt >= 25'(NLP_PERIOD - 1)) begin
      nlp_cnt <= '0;
      nlp_w   <= 2'(NLP_WIDTH_CLK);
    end else begin
      nlp_cnt <= nlp_cnt + 25'h1;
      if (nlp_w != '0) nlp_w <= nlp_w - 2'h1;
    end
  end
  wire idle_line = !tx_en || jab_event;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LINK_PULSE_O <= 1'b0;
      LINE_DATA_O  <= 1'b0;
      LINE_EN_O    <= 1'b0;
    end else begin
      LINK_PULSE_O <= m10 && idle_line && (nlp_w != '0);
      LINE_DATA_O  <= tx_en && !jab_event ? txd : 1'b0;
      LINE_EN_O    <= tx_en && !jab_event;
    end
  end

  // ****************************************
  // polarity
  // ****************************************
  logic       rxp_d, rxn_d, pol_inv;
  logic [1:0] vote;
  // runs in 10M idle or during negotiation
  wire pol_win = (m10 && !rx_act) || an_busy;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rxp_d   <= 1'b0;
      rxn_d   <= 1'b0;
      vote    <= '0;
      pol_inv <= 1'b0;
    end else begin
      rxp_d <= rxp;
      rxn_d <= rxn;
      if (pol_inh) begin
        vote    <= '0;
        pol_inv <= 1'b0;
      end else if (pol_win && rxn && !rxn_d && !rxp) begin
        // pulse leads on negative leg: reversed
        if (vote == 2'(POL_VOTE - 1)) pol_inv <= 1'b1;
        else vote <= vote + 2'h1;
      end else if (pol_win && rxp && !rxp_d && !rxn) begin
        vote    <= '0;
        pol_inv <= 1'b0;
      end
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) RX_DATA_O <= 1'b0;
    else RX_DATA_O <= rxd ^ pol_inv;
  end

  // ****************************************
  // latching flags
  // ****************************************
  logic jab_flag, pol_flag;
  tbts_lh_flag u_jab_flag (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .event_i (jab_event),
    .read_i  (rd17_p),
    .flag_o  (jab_flag)
  );
  tbts_lh_flag u_pol_flag (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .event_i (pol_inv),
    .read_i  (rd18_p),
    .flag_o  (pol_flag)
  );
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      JABBER_FLAG_O  <= 1'b0;
      POL_REV_FLAG_O <= 1'b0;
    end else begin
      JABBER_FLAG_O  <= jab_flag;
      POL_REV_FLAG_O <= pol_flag;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_jab_col: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    jst == TBTS_CUT |=> COL_O) else $error("jabber without collision");
  a_jab_block: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    jst == TBTS_CUT |=> !LINE_EN_O) else $error("data passed in jabber");
  a_jab_flag: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    jst == TBTS_CUT |-> ##2 JABBER_FLAG_O) else $error("jabber flag missing");
  a_jab_inh: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    jab_inh && jst == TBTS_IDLE |=> jst == TBTS_IDLE) else $error("jabber ran inhibited");
  a_sqe_start: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    tx_en_d && !tx_en && sqe_ok && jst != TBTS_CUT |-> ##2 COL_O) else $error("no heartbeat");
  a_sqe_block: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !sqe_ok && sqe_cnt == '0 |=> sqe_cnt == '0) else $error("heartbeat when disabled");
  a_pol_inh: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pol_inh |=> !pol_inv) else $error("correction while inhibited");
  a_pol_inv: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pol_inv |=> RX_DATA_O == !$past(rxd)) else $error("receive not inverted");
endmodule : tbts_top

/* File: dv/tbts_mac_model.sv */
// partner model: mac side sending frames toward the supervision block
`timescale 1ns/1ns
module tbts_mac_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic [31:0] len_i,
  input  wire logic        data_i,
  output logic             tx_en_o,
  output logic             txd_o
);
  int left;
  // falling edge drive keeps clear of the sampling edge
  always @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_en_o <= 1'b0;
      txd_o   <= 1'b0;
      left    <= 0;
    end else if (left > 0) begin
      tx_en_o <= 1'b1;
      txd_o   <= data_i;
      left    <= left - 1;
    end else if (go_i) begin
      left    <= len_i;
    end else begin
      tx_en_o <= 1'b0;
      // idle data toggles so a stale bit never looks valid
      txd_o   <= ~txd_o;
    end
  end
endmodule : tbts_mac_model

/* File: dv/tbts_top_test.sv */
// testbench: self-checking run of the transmit supervision block
`timescale 1ns/1ns
module tbts_top_test
  import tbts_pkg::*;
;
  localparam int JL = 20;
  localparam int JU = 40;
  localparam int NP = 50;
  localparam int JLC = JL * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int JUC = JU * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int SQC = SQE_LEN_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  logic        clk, rst_n, go, dat, tx_en, txd, rxp, rxn, rxd, m10, an, rep, fdx, lnk;
  logic        jinh, sinh, pinh, rd17, rd18, col, ldat, len_o, lp, rxo, jf, pf, plp, ract;
  logic [31:0] rnd;
  int          n_errors, compares, first_col, last_col, col_in, col_after, bad_en, lp_cut;
  int          seen_en, flen, bad_dat;

  tbts_mac_model mac (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .len_i(flen), .data_i(dat),
    .tx_en_o(tx_en), .txd_o(txd));
  tbts_top #(.JAB_LIMIT(JL), .JAB_UNJAB(JU), .SQE_LEN(SQE_LEN_BITS), .NLP_PERIOD(NP)) dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .TX_EN_I(tx_en), .TXD_I(txd),
    .RX_PAIR_POSITIVE_I(rxp), .RX_PAIR_NEGATIVE_I(rxn), .RX_DATA_I(rxd), .RX_ACTIVE_I(ract),
    .MODE_10M_I(m10), .AUTONEG_BUSY_I(an), .REPEATER_MODE_I(rep), .FULL_DUPLEX_I(fdx),
    .LINK_VALID_I(lnk), .JABBER_INHIBIT_I(jinh), .SQE_INHIBIT_I(sinh), .POL_INHIBIT_I(pinh),
    .STATUS17_READ_I(rd17), .STATUS18_READ_I(rd18), .COL_O(col), .LINE_DATA_O(ldat),
    .LINE_EN_O(len_o), .LINK_PULSE_O(lp), .RX_DATA_O(rxo), .JABBER_FLAG_O(jf),
    .POL_REV_FLAG_O(pf));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk

  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge clk);
      rnd = xs(rnd);
      dat <= rnd[0];
    end
  endtask : cyc

  // outputs read at the falling edge, settled since the rising one
  task automatic frame(input int len, input int tail);
    int t;
    int t0;
    logic [1:0] hen;
    logic [1:0] hd;
    t0 = -1;
    hen = '0;
    hd = '0;
    first_col = -1;
    last_col = -1;
    {col_in, col_after, bad_en, lp_cut, seen_en, bad_dat} = '0;
    flen = len;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    for (t = 0; t < len + tail + 4; t++) begin
      cyc(1);
      if (tx_en && t0 < 0) t0 = t;
      if (t0 >= 0) begin
        if (col && first_col < 0) first_col = t - t0;
        if (col) last_col = t - t0;
        if (tx_en) col_in += col;
        else col_after += col;
        if (tx_en) seen_en += len_o;
        if (tx_en && col && t - t0 > first_col + 4) bad_en += len_o | ldat;
        if (col && lp && !plp) lp_cut++;
      end
      plp = lp;
      // line data trails pin data by two samples unless cut
      if (hen[1] && !col) bad_dat += (ldat !== hd[1]);
      hen = {hen[0], tx_en};
      hd = {hd[0], txd};
    end
  endtask : frame

  task automatic leg(input logic rev);
    rxp <= !rev;
    rxn <= rev;
    cyc(3);
    {rxp, rxn} <= 2'b00;
    cyc(6);
  endtask : leg

  task automatic pulse_rd(input int which);
    if (which == 17) rd17 <= 1'b1;
    else rd18 <= 1'b1;
    cyc(2);
    {rd17, rd18} <= 2'b00;
    cyc(6);
  endtask : pulse_rd

  initial begin
    int i, j, k, r, h;
    {rst_n, go, dat, rxp, rxn, rxd, an, rep, fdx, jinh, sinh, pinh, rd17, rd18, ract} = '0;
    {m10, lnk} = 2'b11;
    rnd = 32'h0000005F;
    flen = 1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset outs", 0, {col, ldat, len_o, lp, rxo, jf, pf});
    rst_n <= 1'b1;
    cyc(8);
    for (k = 0; k < 2; k++) begin
      m10 <= (k == 0);
      cyc(6);
      {r, h} = '0;
      plp = lp;
      repeat (4 * NP) begin
        cyc(1);
        r += lp && !plp;
        h += lp;
        plp = lp;
      end
      chk("nlp count", k == 0 ? 4 : 0, r);
      chk("nlp width", k == 0 ? 12 : 0, h);
    end
    m10 <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rep <= (i == 0);
      fdx <= (i == 1);
      lnk <= (i != 2);
      sinh <= (i == 3);
      cyc(6);
      frame(10, 40);
      chk("sqe cycles", i == 4 ? SQC : 0, col_after);
      chk("frame col", 0, col_in);
      chk("line data", 0, bad_dat);
    end
    chk("line en", 1, seen_en > 0);
    sinh <= 1'b1;
    frame(100, 130);
    chk("jab start", 1, first_col >= JLC && first_col <= JLC + 12);
    chk("jab span", 1, last_col - first_col >= JUC - 2 &&
        last_col - first_col <= JUC + 8);
    chk("cut line en", 0, bad_en);
    chk("jab line data", 0, bad_dat);
    chk("cut pulses", 1, lp_cut > 0);
    chk("jab flag", 1, jf);
    pulse_rd(17);
    chk("jab flag read", 0, jf);
    jinh <= 1'b1;
    frame(100, 20);
    chk("inhibit col", 0, col_in);
    chk("inhibit flag", 0, jf);
    for (j = 0; j < 4; j++) begin
      m10 <= (j != 1);
      an <= (j == 1);
      pinh <= (j == 2);
      ract <= (j == 3);
      cyc(6);
      leg(1);
      leg(1);
      chk("pol flag", j < 2, pf);
      rxd <= rnd[1];
      cyc(6);
      chk("rx inverted", rxd ^ (j < 2), rxo);
      leg(0);
      rxd <= rnd[2];
      cyc(6);
      chk("rx restored", rxd, rxo);
      chk("pol latched", j < 2, pf);
      pulse_rd(18);
      chk("pol flag read", 0, pf);
    end
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : tbts_top_test
